// file: core/dpa_pkg.sv
package dpa_pkg;

  // ---------------------------------------------------------------
  // Register map and field layout
  // ---------------------------------------------------------------
  localparam int DPA_ADR_W = 8;
  localparam logic [7:0] DPA_CFG_OFS = 8'h94;
  localparam logic [7:0] DPA_SEL_OFS = 8'h98;
  localparam logic [7:0] DPA_DATA_OFS = 8'h9C;
  localparam int DPA_SEL_DONE_BIT = 31;
  localparam int DPA_SEL_DIR_BIT = 30;
  localparam int DPA_IDX_W = 30;
  localparam int DPA_CFG_VALID_BIT = 3;
  localparam int DPA_CFG_FREQ_LSB = 0;
  localparam int DPA_CFG_FREQ_W = 3;
  localparam logic [3:0] DPA_SEL_FULL = 4'hF;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [29:0] DPA_IDX_RST = 30'h0000_0000;
  localparam logic DPA_DIR_RST = 1'b0;
  localparam logic DPA_DONE_RST = 1'b1;
  localparam logic [31:0] DPA_DATA_RST = 32'h0000_0000;
  localparam logic DPA_VALID_RST = 1'b0;
  localparam logic [2:0] DPA_FREQ_RST = 3'h0;
  localparam logic [31:0] DPA_RST_DRV_COMP = 32'h0011_1222;
  localparam logic [31:0] DPA_RST_WR_TIME_LO = 32'h1717_1717;
  localparam logic [31:0] DPA_RST_OTHER = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Indirect index space
  // ---------------------------------------------------------------
  localparam int DPA_SLOTS_PER_CH = 12;
  localparam int DPA_NUM_SLOTS = 24;
  localparam int DPA_SLOT_W = 5;
  localparam int DPA_CH_B_BIT = 5;
  localparam logic [4:0] DPA_IDX_LAST_TIMING = 5'h07;
  localparam logic [4:0] DPA_IDX_RXEN0 = 5'h10;
  localparam logic [4:0] DPA_IDX_RXEN1 = 5'h13;
  localparam logic [4:0] DPA_IDX_RXEN2 = 5'h16;
  localparam logic [4:0] DPA_IDX_RXEN3 = 5'h19;
  localparam logic [4:0] DPA_SLOT_RXEN0 = 5'd8;
  localparam logic [4:0] DPA_SLOT_CH_B = 5'd12;
  localparam logic [4:0] DPA_SLOT_DRV_COMP = 5'd0;
  localparam logic [4:0] DPA_SLOT_WR_TIME_LO = 5'd1;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int DPA_CLK_PERIOD_NS = 4;
  localparam int DPA_PHY_ACCESS_NS = 20;
  localparam int DPA_PHY_ACCESS_CYCLES =
    (DPA_PHY_ACCESS_NS + DPA_CLK_PERIOD_NS - 1) / DPA_CLK_PERIOD_NS;
  localparam int DPA_CNT_W = 4;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DPA_IDLE  = 3'b001,
    DPA_ISSUE = 3'b010,
    DPA_WAIT  = 3'b100
  } dpa_state_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic [29:0] index;
    logic [31:0] wdata;
  } dpa_phy_req_s;

  typedef struct packed {
    logic done;
    logic hit;
    logic [31:0] rdata;
  } dpa_phy_rsp_s;

  typedef logic [DPA_NUM_SLOTS-1:0][31:0] dpa_regs_t;

endpackage

// file: core/dpa_phy_bank.sv
`timescale 1ns/10ps

// Physical-layer timing and drive register bank with a fixed access delay
module dpa_phy_bank
  import dpa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dpa_phy_req_s req_i,
  output dpa_phy_rsp_s rsp_o,
  output dpa_regs_t regs_o
);

  dpa_regs_t regs_q;
  dpa_phy_req_s pend_q;
  logic busy_q;
  logic [DPA_CNT_W-1:0] cnt_q;
  logic hit;
  logic [DPA_SLOT_W-1:0] slot;

  // ---------------------------------------------------------------
  // Index decode: eight timing registers, four receive enables
  // ---------------------------------------------------------------
  always_comb begin
    logic [4:0] low;
    low = pend_q.index[4:0];
    hit = (pend_q.index[DPA_IDX_W-1:DPA_CH_B_BIT+1] == '0);
    slot = low;
    if (low <= DPA_IDX_LAST_TIMING) begin
      slot = low;
    end else if (low == DPA_IDX_RXEN0) begin
      slot = DPA_SLOT_RXEN0;
    end else if (low == DPA_IDX_RXEN1) begin
      slot = DPA_SLOT_RXEN0 + 5'd1;
    end else if (low == DPA_IDX_RXEN2) begin
      slot = DPA_SLOT_RXEN0 + 5'd2;
    end else if (low == DPA_IDX_RXEN3) begin
      slot = DPA_SLOT_RXEN0 + 5'd3;
    end else begin
      hit = 1'b0;
    end
    if (pend_q.index[DPA_CH_B_BIT]) begin
      slot = slot + DPA_SLOT_CH_B;
    end
  end

  // ---------------------------------------------------------------
  // Request capture and access delay
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= '0;
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else if (!busy_q && req_i.valid) begin
      pend_q <= req_i;
      busy_q <= 1'b1;
      cnt_q <= DPA_CNT_W'(DPA_PHY_ACCESS_CYCLES - 1);
    end else if (busy_q && cnt_q == '0) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // Storage; writes to unlisted indices are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DPA_NUM_SLOTS; i++) begin
        if (i % DPA_SLOTS_PER_CH == int'(DPA_SLOT_DRV_COMP)) begin
          regs_q[i] <= DPA_RST_DRV_COMP;
        end else if (i % DPA_SLOTS_PER_CH == int'(DPA_SLOT_WR_TIME_LO)) begin
          regs_q[i] <= DPA_RST_WR_TIME_LO;
        end else begin
          regs_q[i] <= DPA_RST_OTHER;
        end
      end
    end else if (busy_q && cnt_q == '0 && pend_q.write && hit) begin
      regs_q[slot] <= pend_q.wdata;
    end
  end

  // Completion answer, one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.done <= busy_q && cnt_q == '0;
      rsp_o.hit <= hit;
      rsp_o.rdata <= hit ? regs_q[slot] : '0;
    end
  end

  assign regs_o = regs_q;

endmodule

// file: core/dpa_port.sv
`timescale 1ns/10ps

// Summary of operation
// - The selector holds a 30-bit read/write index in its low bits, zero after reset.
// - Bit 30 of the selector is a write-only direction bit, zero after reset, 1 meaning write.
// - Bit 31 of the selector is a read-only done flag, 1 after reset and whenever idle.
// - The done flag reads 0 while an indirect access is being carried out.
// - A read loads the data port on the same edge that raises the done flag.
// - A write delivers the data port value to the target and only then raises done.
// - Indices 0 to 7 select the eight first-channel timing and drive registers in order.
// - Indices 20h to 27h select the same eight registers of the second channel.
// - Indices 10h, 13h, 16h, 19h and their 30h twins select receive enable timing per pair.
// - In one package variant the 16h entry controls chip selects 3 and 2 of the first DIMM.
// - The data port is a 32-bit read/write register, zero after reset.
// - The memory clock valid bit lets the controller start driving the memory clock.
module dpa_port
  import dpa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [DPA_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Package variant strap pin
  input wire logic pkg_variant_i,
  // Controller side
  output logic memory_interface_clock_en_o,
  output logic [2:0] memory_interface_clock_freq_o,
  output logic rxen_pair2_alt_map_o,
  output logic access_busy_o,
  output dpa_regs_t phy_regs_o
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  // Sequencer and selector state
  dpa_state_e state_q;
  dpa_state_e state_d;
  logic [DPA_IDX_W-1:0] target_index_q;
  logic direction_select_q;
  logic access_complete_flag_q;
  logic busy_q;
  logic [31:0] indirect_data_word_q;

  // Controller configuration
  logic memory_interface_clock_setting_valid_q;
  logic [2:0] memory_interface_clock_freq_q;

  // Bus answer
  logic ack_q;
  logic [31:0] rdat_q;

  // Strap capture
  logic variant_meta_q;
  logic variant_sync_q;
  logic variant_q;
  logic strap_taken_q;

  // Decode strobes
  logic bus_take;
  logic wr_full;
  logic wr_sel;
  logic wr_data;
  logic wr_cfg;
  logic start;
  logic access_end;

  // Bank link and read views
  dpa_phy_req_s phy_req;
  dpa_phy_rsp_s phy_rsp;
  logic [31:0] sel_view;
  logic [31:0] cfg_view;
  logic [31:0] rd_mux;

  // ---------------------------------------------------------------
  // Wishbone decode
  // ---------------------------------------------------------------

  // A request is taken once, on the edge that raises ack; a master that
  // leaves stb up for the ack cycle is not taken a second time
  assign bus_take = wb_cyc_i && wb_stb_i && !ack_q;

  // Only whole-word writes are honoured
  // Partial writes are still acked so the master never hangs
  assign wr_full = bus_take && wb_we_i && (wb_sel_i == DPA_SEL_FULL);

  // Per-register write strobes
  // Addresses compare in full, so nothing aliases into the window
  assign wr_sel = wr_full && (wb_adr_i == DPA_SEL_OFS);
  assign wr_data = wr_full && (wb_adr_i == DPA_DATA_OFS);
  assign wr_cfg = wr_full && (wb_adr_i == DPA_CFG_OFS);

  // A selector write while idle launches an indirect access
  // A selector write while busy is dropped, so the index stays put
  assign start = wr_sel && (state_q == DPA_IDLE);

  // Ack, one cycle after the request is taken
  // Fixed latency: every request, mapped or not, sees one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_take;
    end
  end

  assign wb_ack_o = ack_q;

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------

  // Selector view: direction bit is write-only and reads as zero
  // Bit 31 is the live done flag; the index reads back as held
  always_comb begin
    sel_view = '0;
    sel_view[DPA_SEL_DONE_BIT] = access_complete_flag_q;
    sel_view[DPA_IDX_W-1:0] = target_index_q;
  end

  // Configuration view
  // Only the clock valid and frequency fields are kept
  always_comb begin
    cfg_view = '0;
    cfg_view[DPA_CFG_VALID_BIT] = memory_interface_clock_setting_valid_q;
    cfg_view[DPA_CFG_FREQ_LSB +: DPA_CFG_FREQ_W] = memory_interface_clock_freq_q;
  end

  // Address mux; unmapped addresses read as zero
  // Decoded from the live address; the result is caught with the ack
  always_comb begin
    case (wb_adr_i)
      DPA_SEL_OFS: begin
        rd_mux = sel_view;
      end
      DPA_DATA_OFS: begin
        rd_mux = indirect_data_word_q;
      end
      DPA_CFG_OFS: begin
        rd_mux = cfg_view;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Read data registered with the ack
  // Writes return zero so stale read data never shows on the bus
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= '0;
    end else if (bus_take) begin
      rdat_q <= wb_we_i ? '0 : rd_mux;
    end
  end

  assign wb_dat_o = rdat_q;

  // ---------------------------------------------------------------
  // Controller configuration
  // ---------------------------------------------------------------

  // Memory clock setting and its valid bit
  // Partial writes leave both fields untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      memory_interface_clock_setting_valid_q <= DPA_VALID_RST;
      memory_interface_clock_freq_q <= DPA_FREQ_RST;
    end else if (wr_cfg) begin
      memory_interface_clock_setting_valid_q <= wb_dat_i[DPA_CFG_VALID_BIT];
      memory_interface_clock_freq_q <= wb_dat_i[DPA_CFG_FREQ_LSB +: DPA_CFG_FREQ_W];
    end
  end

  // Clock drive starts once software declares the setting valid
  // Accesses made before this bit is set are not blocked here
  assign memory_interface_clock_en_o = memory_interface_clock_setting_valid_q;
  assign memory_interface_clock_freq_o = memory_interface_clock_freq_q;

  // ---------------------------------------------------------------
  // Selector fields
  // ---------------------------------------------------------------

  // Index and direction are loaded only when an access can start
  // Holding them through an access keeps the bank request steady
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_index_q <= DPA_IDX_RST;
      direction_select_q <= DPA_DIR_RST;
    end else if (start) begin
      target_index_q <= wb_dat_i[DPA_IDX_W-1:0];
      direction_select_q <= wb_dat_i[DPA_SEL_DIR_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Access sequencer
  // ---------------------------------------------------------------

  // Next state
  // ISSUE lasts one cycle so the bank sees a single request pulse
  // WAIT ends only on the bank's done pulse
  always_comb begin
    state_d = state_q;
    case (state_q)
      DPA_IDLE: begin
        if (start) begin
          state_d = DPA_ISSUE;
        end
      end
      DPA_ISSUE: begin
        state_d = DPA_WAIT;
      end
      DPA_WAIT: begin
        if (phy_rsp.done) begin
          state_d = DPA_IDLE;
        end
      end
      default: begin
        state_d = DPA_IDLE;
      end
    endcase
  end

  // State register
  // Reset lands in idle, matching the done flag at one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= DPA_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // The cycle in which the bank reports the access finished
  assign access_end = (state_q == DPA_WAIT) && phy_rsp.done;

  // One-cycle request towards the bank, taken from the held fields
  // The data word is frozen by the idle-only write rule below
  always_comb begin
    phy_req.valid = (state_q == DPA_ISSUE);
    phy_req.write = direction_select_q;
    phy_req.index = target_index_q;
    phy_req.wdata = indirect_data_word_q;
  end

  // Done flag: low from the launch until the bank reports completion
  // Start and completion never meet: start needs the idle state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      access_complete_flag_q <= DPA_DONE_RST;
    end else if (start) begin
      access_complete_flag_q <= 1'b0;
    end else if (access_end) begin
      access_complete_flag_q <= 1'b1;
    end
  end

  // Busy pin from its own flop, the inverse of the done flag
  // Kept apart so the status pin never depends on a gate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= !DPA_DONE_RST;
    end else if (start) begin
      busy_q <= 1'b1;
    end else if (access_end) begin
      busy_q <= 1'b0;
    end
  end

  assign access_busy_o = busy_q;

  // ---------------------------------------------------------------
  // Data port
  // ---------------------------------------------------------------

  // Software writes while idle; read results land with the done flag
  // Bus writes during an access are dropped so the word in flight holds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      indirect_data_word_q <= DPA_DATA_RST;
    end else if (access_end && !direction_select_q) begin
      indirect_data_word_q <= phy_rsp.rdata;
    end else if (wr_data && state_q == DPA_IDLE) begin
      indirect_data_word_q <= wb_dat_i;
    end
  end

  // ---------------------------------------------------------------
  // Package variant strap
  // ---------------------------------------------------------------

  // Two-stage synchroniser for the strap pin
  // Left out of reset: it holds the settled pin level when reset ends,
  // so the one-shot capture below sees the real strap
  always_ff @(posedge clk_i) begin
    variant_meta_q <= pkg_variant_i;
    variant_sync_q <= variant_meta_q;
  end

  // Strap is caught once, after reset release, once synchronised
  // Later pin changes are ignored until the next reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_taken_q <= 1'b0;
      variant_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      variant_q <= variant_sync_q;
    end
  end

  // Tells the PHY that pair-2 receive enable drives DIMM 0 CS 3:2
  // A plain level; the bank itself remaps nothing
  assign rxen_pair2_alt_map_o = variant_q;

  // ---------------------------------------------------------------
  // Physical-layer register bank
  // ---------------------------------------------------------------

  // Bank carrying the indirect registers, with its fixed access delay
  // Its hit flag is not needed: misses already read as zero
  dpa_phy_bank dpa_phy_bank_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(phy_req),
    .rsp_o(phy_rsp),
    .regs_o(phy_regs_o)
  );

endmodule

// file: verification/dpa_port_sva.sv
`timescale 1ns/10ps

// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module dpa_port_sva
  import dpa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [DPA_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic memory_interface_clock_en_o,
  input wire logic [2:0] memory_interface_clock_freq_o,
  input wire logic access_busy_o,
  input wire dpa_regs_t phy_regs_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Request taken, selector write that starts an access, cfg write
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_go;
    s_take ##0 (wb_we_i && wb_adr_i == DPA_SEL_OFS
      && wb_sel_i == DPA_SEL_FULL && !access_busy_o);
  endsequence
  sequence s_cfg_wr;
    wb_ack_o && wb_we_i && wb_adr_i == DPA_CFG_OFS
      && wb_sel_i == DPA_SEL_FULL;
  endsequence

  a_ack_after_take: assert property (s_take |=> wb_ack_o)
    else $error("no ack after a request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without a request");
  a_wr_data_zero: assert property (
    wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero on a write");
  a_dir_reads_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == DPA_SEL_OFS
      |-> !wb_dat_o[DPA_SEL_DIR_BIT])
    else $error("direction bit readable");
  a_go_sets_busy: assert property (s_go |-> ##[1:2] access_busy_o)
    else $error("access start not seen as busy");
  a_busy_min_len: assert property (
    $rose(access_busy_o) |-> access_busy_o[*4])
    else $error("busy too short");
  a_busy_ends: assert property (
    $rose(access_busy_o) |-> ##[4:12] !access_busy_o)
    else $error("busy never ends");
  a_cfg_to_clock: assert property (s_cfg_wr |=>
    memory_interface_clock_en_o == $past(wb_dat_i[DPA_CFG_VALID_BIT])
      && memory_interface_clock_freq_o == $past(wb_dat_i[2:0]))
    else $error("clock outputs do not follow cfg");
  a_phy_idle_quiet: assert property (
    !$stable(phy_regs_o) |-> $past(access_busy_o)
      || $past(access_busy_o, 2))
    else $error("bank changed with no access");
endmodule

bind dpa_port dpa_port_sva dpa_port_sva_inst (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .memory_interface_clock_en_o,
  .memory_interface_clock_freq_o, .access_busy_o, .phy_regs_o
);

// file: verification/dpa_phy_ref.sv
`timescale 1ns/10ps

// Reference image of the timing and drive bank beyond the port
module dpa_phy_ref
  import dpa_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [4:0] slot_i,
  input wire logic [31:0] data_i,
  output dpa_regs_t regs_o
);
  // Reset image, then each delivered write lands in its slot
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      regs_o <= {DPA_NUM_SLOTS{DPA_RST_OTHER}};
      regs_o[DPA_SLOT_DRV_COMP] <= DPA_RST_DRV_COMP;
      regs_o[DPA_SLOT_DRV_COMP + DPA_SLOT_CH_B] <=
        DPA_RST_DRV_COMP;
      regs_o[DPA_SLOT_WR_TIME_LO] <= DPA_RST_WR_TIME_LO;
      regs_o[DPA_SLOT_WR_TIME_LO + DPA_SLOT_CH_B] <=
        DPA_RST_WR_TIME_LO;
    end else if (wr_i) begin
      regs_o[slot_i] <= data_i;
    end
  end
endmodule

// file: verification/dpa_port_tb.sv
`timescale 1ns/10ps

module dpa_port_tb
  import dpa_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic pkg_variant_i = 1'b1;
  logic [31:0] wb_dat_o, rdat, d;
  logic wb_ack_o, memory_interface_clock_en_o, rxen_pair2_alt_map_o;
  logic access_busy_o;
  logic [2:0] memory_interface_clock_freq_o;
  dpa_regs_t phy_regs_o, exp_regs;
  logic m_wr = 1'b0;
  logic [5:0] m_idx = 6'h00;
  logic [31:0] m_data = 32'h0000_0000;
  logic [5:0] i6;
  logic [71:0] exp_q[$];
  logic [71:0] note;
  logic [29:0] rsv [6] = '{30'h0000_0008, 30'h0000_0011, 30'h0000_001B,
    30'h0000_003A, 30'h0000_0040, 30'h3FFF_FFFF};
  int err_total = 0;
  int n_checks = 0;

  // Clock
  always #2 clk_i = ~clk_i;

  dpa_port dpa_port_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pkg_variant_i,
    .memory_interface_clock_en_o, .memory_interface_clock_freq_o,
    .rxen_pair2_alt_map_o, .access_busy_o, .phy_regs_o);

  dpa_phy_ref dpa_phy_ref_inst (.clk_i, .rst_i, .wr_i(m_wr),
    .slot_i(m_idx[4] ? 5'h08 + 5'((m_idx[4:0] - 5'h10) / 3) + 5'(m_idx[5] * 12)
      : {2'b00, m_idx[2:0]} + 5'(m_idx[5] * 12)),
    .data_i(m_data), .regs_o(exp_regs));

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] v, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= v;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n == 20) begin
      err_total++;
      $display("Error ack timeout");
      print_verdict();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    exp_q.push_back({a, m, e});
    wb(1'b0, a, 32'h0000_0000, DPA_SEL_FULL);
  endtask

  task automatic poll(input logic [29:0] i, input logic [31:0] m);
    int n;
    n = 0;
    rd(DPA_SEL_OFS, {2'b00, i}, m);
    while (rdat[DPA_SEL_DONE_BIT] !== 1'b1 && n < 20) begin
      rd(DPA_SEL_OFS, 32'h0000_0000, 32'h0000_0000);
      n++;
    end
    if (rdat[DPA_SEL_DONE_BIT] !== 1'b1) begin
      err_total++;
      $display("Error done flag timeout");
      print_verdict();
    end
    rd(DPA_SEL_OFS, {2'b10, i}, 32'hFFFF_FFFF);
  endtask

  task automatic ind_wr(input logic [29:0] i, input logic [31:0] v);
    wb(1'b1, DPA_DATA_OFS, v, DPA_SEL_FULL);
    wb(1'b1, DPA_SEL_OFS, {2'b01, i}, DPA_SEL_FULL);
    poll(i, 32'hFFFF_FFFF);
  endtask

  task automatic ind_rd(input logic [29:0] i, input logic [31:0] e);
    wb(1'b1, DPA_SEL_OFS, {2'b00, i}, DPA_SEL_FULL);
    poll(i, 32'hFFFF_FFFF);
    rd(DPA_DATA_OFS, e, 32'hFFFF_FFFF);
  endtask

  task automatic phy_cmp();
    #1;
    for (int k = 0; k < DPA_NUM_SLOTS; k++) begin
      chk("bank slot", phy_regs_o[k], exp_regs[k]);
    end
  endtask

  // Oldest read note is popped on each read answer and compared under its mask
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[63:32] != 32'h0000_0000) begin
        chk($sformatf("read data at %h", note[71:64]),
          wb_dat_o & note[63:32], note[31:0] & note[63:32]);
      end
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(47288));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rd(DPA_SEL_OFS, 32'h8000_0000, 32'hFFFF_FFFF);
    rd(DPA_DATA_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(DPA_CFG_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0000_0000, 32'hFFFF_FFFF);
    phy_cmp();
    chk("strap map", {31'h0, rxen_pair2_alt_map_o}, 32'h1);
    $display("test reset done");
    wb(1'b1, DPA_CFG_OFS, 32'h0000_000B, DPA_SEL_FULL);
    #1;
    chk("clock en", {31'h0, memory_interface_clock_en_o}, 32'h1);
    chk("clock freq", {29'h0, memory_interface_clock_freq_o}, 32'h3);
    $display("test cfg done");
    for (int ch = 0; ch < 2; ch++) begin
      for (int k = 0; k < 12; k++) begin
        i6 = 6'(k < 8 ? k : 16 + 3 * (k - 8)) | 6'(ch * 32);
        d = $urandom();
        ind_wr({24'h0, i6}, d);
        @(posedge clk_i);
        m_wr <= 1'b1;
        m_idx <= i6;
        m_data <= d;
        @(posedge clk_i);
        m_wr <= 1'b0;
        phy_cmp();
        wb(1'b1, DPA_DATA_OFS, ~d, DPA_SEL_FULL);
        ind_rd({24'h0, i6}, d);
      end
    end
    $display("test listed indices done");
    for (int r = 0; r < 6; r++) begin
      ind_wr(rsv[r], $urandom());
      phy_cmp();
      ind_rd(rsv[r], 32'h0000_0000);
    end
    $display("test reserved indices done");
    wb(1'b1, DPA_DATA_OFS, 32'hA5A5_A5A5, 4'h3);
    rd(DPA_DATA_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    wb(1'b1, DPA_SEL_OFS, 32'h0000_0001, DPA_SEL_FULL);
    wb(1'b1, DPA_SEL_OFS, 32'h4000_0002, DPA_SEL_FULL);
    poll(30'h0000_0001, 32'h7FFF_FFFF);
    rd(DPA_DATA_OFS, exp_regs[1], 32'hFFFF_FFFF);
    phy_cmp();
    $display("test refusals done");
    @(posedge clk_i);
    pkg_variant_i <= 1'b0;
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk("strap map", {31'h0, rxen_pair2_alt_map_o}, 32'h0);
    rd(DPA_SEL_OFS, 32'h8000_0000, 32'hFFFF_FFFF);
    rd(DPA_DATA_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    phy_cmp();
    $display("test second reset done");
    repeat (4) @(posedge clk_i);
    print_verdict();
  end
endmodule
